/* rtl/dsc_pkg.sv */
// constants shared by the strobe capture control block and its calibration loops
// assumes one core clock domain; strobe, data and routing clocks arrive unsynchronised
// Function
// RULE_01 - register clock from routing or strobe
// RULE_02 - selected clock passes optional inversion
// RULE_03 - enable and reset from routing, each invertible
// RULE_04 - global tristate forwarded without change
// RULE_05 - double-rate registers on input and output
// RULE_06 - strobe pins feed delay onto strobe net
// RULE_07 - strobe drives sync register polarity logic
// RULE_08 - delay set by six-bit calibration code
// RULE_09 - two loops, each serves own half
// RULE_10 - loop tracks via system clock and feedback
// RULE_11 - code changes only between strobe bursts
package dsc_pkg;
	// ----------------------------------------
	// structure
	// ----------------------------------------
	localparam int N_HALF = 2; // one strobe channel per half
	localparam int N_RT_CLK = 4; // routing clocks offered
	localparam int CODE_W = 6; // calibration code width
	localparam int TAPS = 64; // delay taps, one per code value
	localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
	localparam logic [2:0] SEL_STROBE = 3'h4; // select value for strobe net
	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CODE = 8'h0c;
	// ctrl fields
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_INV_BIT = 3;
	localparam int CTRL_CE_INV_BIT = 4;
	localparam int CTRL_RST_INV_BIT = 5;
	localparam int CTRL_OE_BIT = 6;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [3:0] TX_RST = 4'h0;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// cycle counts
	// ----------------------------------------
	localparam logic [4:0] IDLE_CYC = 5'h10; // quiet strobe cycles that end a burst
	localparam logic [7:0] CAL_GAP_CYC = 8'h7f; // spacing between loop launches
	localparam logic [7:0] CAL_TMO_CYC = 8'hff; // loop gives up waiting
endpackage : dsc_pkg

/* rtl/cal_loop.sv */
// one calibration loop: launches a level change, times its return through feedback
// assumes the feedback pin is asynchronous and returns the launch level unchanged
`timescale 1ns/1ps
module cal_loop (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_fb,
	output logic o_launch,
	output logic [dsc_pkg::CODE_W-1:0] o_code,
	output logic o_lock
);
	import dsc_pkg::*;

	typedef enum logic {CAL_GAP, CAL_MEAS} cal_state_t;

	cal_state_t state_r, state_nxt; // gap or measuring
	logic fb_m_r, fb_s_r; // feedback synchroniser
	logic launch_r, launch_nxt; // launched level
	logic [7:0] cnt_r, cnt_nxt; // cycle counter
	logic [CODE_W-1:0] code_r, code_nxt; // measured code
	logic lock_r, lock_nxt; // two equal measures in a row

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		launch_nxt = launch_r;
		cnt_nxt = cnt_r + 8'h01;
		code_nxt = code_r;
		lock_nxt = lock_r;
		case (state_r)
			CAL_GAP: begin
				// wait so the feedback path settles between launches
				if (cnt_r == CAL_GAP_CYC) begin
					launch_nxt = ~launch_r;
					cnt_nxt = 8'h00;
					state_nxt = CAL_MEAS;
				end
			end
			CAL_MEAS: begin
				// returned level closes the loop; round trip becomes the code [RULE_10]
				if (fb_s_r == launch_r) begin
					code_nxt = (cnt_r > {2'h0, CODE_MAX}) ? CODE_MAX : cnt_r[CODE_W-1:0];
					lock_nxt = (code_nxt == code_r);
					cnt_nxt = 8'h00;
					state_nxt = CAL_GAP;
				end else if (cnt_r == CAL_TMO_CYC) begin
					// broken feedback: longest delay, not locked
					code_nxt = CODE_MAX;
					lock_nxt = 1'b0;
					cnt_nxt = 8'h00;
					state_nxt = CAL_GAP;
				end
			end
			default: begin
				state_nxt = CAL_GAP;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= CAL_GAP;
			fb_m_r <= 1'b0;
			fb_s_r <= 1'b0;
			launch_r <= 1'b0;
			cnt_r <= 8'h00;
			code_r <= CODE_MAX;
			lock_r <= 1'b0;
		end else if (i_ce) begin
			state_r <= state_nxt;
			fb_m_r <= i_fb;
			fb_s_r <= fb_m_r;
			launch_r <= launch_nxt;
			cnt_r <= cnt_nxt;
			code_r <= code_nxt;
			lock_r <= lock_nxt;
		end
	end

	assign o_launch = launch_r;
	assign o_code = code_r;
	assign o_lock = lock_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_cal_code;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && state_r == CAL_MEAS && fb_s_r == launch_r && cnt_r < 8'h40) |=> (o_code == $past(cnt_r[5:0]));
	endproperty
	a_cal_code: assert property (p_cal_code) else $error("loop code differs from round trip"); // [RULE_10]

	property p_cal_lock;
		@(posedge i_clk) disable iff (!i_rst_n) $rose(lock_r);
	endproperty
	c_cal_lock: cover property (p_cal_lock);
endmodule : cal_loop

/* rtl/ddr_strobe_capture_control.sv */
// strobe capture control: clock, enable and reset selection, strobe delay and
// polarity, double-rate capture and launch, two calibration loops, axi4-lite registers
// assumes routing enable, reset and global tristate are on the core clock
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ddr_strobe_capture_control (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic [dsc_pkg::N_RT_CLK-1:0] I_RT_CLK,
	input wire logic [dsc_pkg::N_HALF-1:0] I_DQS,
	input wire logic [dsc_pkg::N_HALF-1:0] I_DQ,
	input wire logic I_IO_CE,
	input wire logic I_IO_LSR,
	input wire logic I_GTS,
	input wire logic [dsc_pkg::N_HALF-1:0] I_CAL_FB,
	output logic [dsc_pkg::N_HALF-1:0] O_CAL_LAUNCH,
	output logic [dsc_pkg::N_HALF-1:0] O_DQS_DLY,
	output logic [dsc_pkg::N_HALF-1:0] O_DQ,
	output logic [dsc_pkg::N_HALF-1:0] O_DQ_OE_N,
	output logic O_SEL_CLK,
	output logic O_GTS,
	input wire logic [7:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [7:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY
);
	import dsc_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [6:0] ctrl_r, ctrl_nxt; // clock select, inversions, output enable
	logic [3:0] tx_r, tx_nxt; // {fall bits, rise bits} to launch
	logic aw_ok_r, aw_ok_nxt; // write address held
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic w_ok_r, w_ok_nxt; // write data held
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [N_RT_CLK-1:0] rt_m_r, rt_s_r; // routing clock synchroniser
	logic sel_raw; // selected clock before inversion
	logic sel_clk_r, sel_prev_r; // selected clock and its last value
	logic sel_rise, sel_fall; // edges of the selected clock
	logic gts_r; // forwarded global tristate
	logic ce_eff, rst_eff; // enable and reset after polarity
	wire logic [N_HALF-1:0] dly_w, pol_w, idle_w, lock_w;
	wire logic [2*N_HALF-1:0] sync_w;
	wire logic [CODE_W-1:0] code_app_w [N_HALF];
	wire logic [CODE_W-1:0] cal_code_w [N_HALF];

	// ----------------------------------------
	// control selection
	// ----------------------------------------
	// clock from routing or from the delayed strobe net of the lower half [RULE_01]
	always_comb begin
		if (ctrl_r[CTRL_SEL_LSB+2:CTRL_SEL_LSB] == SEL_STROBE) begin
			sel_raw = dly_w[0];
		end else if (ctrl_r[CTRL_SEL_LSB+2] == 1'b0) begin
			sel_raw = rt_s_r[ctrl_r[CTRL_SEL_LSB+1:CTRL_SEL_LSB]];
		end else begin
			sel_raw = 1'b0; // unused codes park the clock low
		end
	end

	assign sel_rise = sel_clk_r & ~sel_prev_r;
	assign sel_fall = ~sel_clk_r & sel_prev_r;
	assign ce_eff = I_IO_CE ^ ctrl_r[CTRL_CE_INV_BIT]; // [RULE_03]
	assign rst_eff = I_IO_LSR ^ ctrl_r[CTRL_RST_INV_BIT]; // [RULE_03]

	// synchronisers, clock inversion stage, tristate forwarding
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rt_m_r <= '0;
			rt_s_r <= '0;
			sel_clk_r <= 1'b0;
			sel_prev_r <= 1'b0;
			gts_r <= 1'b0;
		end else if (I_CE) begin
			rt_m_r <= I_RT_CLK;
			rt_s_r <= rt_m_r;
			sel_clk_r <= sel_raw ^ ctrl_r[CTRL_INV_BIT]; // [RULE_02]
			sel_prev_r <= sel_clk_r;
			gts_r <= I_GTS; // no select, no inversion [RULE_04]
		end
	end

	assign O_SEL_CLK = sel_clk_r;
	assign O_GTS = gts_r;

	// ----------------------------------------
	// per half: loop, delay, polarity, capture, launch
	// ----------------------------------------
	for (genvar c = 0; c < N_HALF; c++) begin : g_half
		logic dqs_m_r, dqs_s_r, dq_m_r, dq_s_r; // pin synchronisers
		logic [TAPS-1:0] line_r, line_nxt; // strobe delay taps
		logic dly_r, dly_nxt, dly_prev_r; // delayed strobe
		logic rise_q_r, rise_q_nxt, fall_q_r, fall_q_nxt; // double-rate input pair
		logic pol_r, pol_nxt; // burst opened with a rising edge
		logic [4:0] idle_cnt_r, idle_cnt_nxt;
		logic [CODE_W-1:0] code_app_r, code_app_nxt; // code in use by the taps
		logic [1:0] sync_r, sync_nxt; // {second, first} half of the pair
		logic dq_out_r, dq_out_nxt; // double-rate output register
		logic oe_n_r, oe_n_nxt;
		logic dly_rise, dly_fall, idle;

		// each half owns its loop [RULE_09]
		cal_loop u_cal (
			.i_clk(I_CORE_CLK),
			.i_rst_n(I_RST_N),
			.i_ce(I_CE),
			.i_fb(I_CAL_FB[c]),
			.o_launch(O_CAL_LAUNCH[c]),
			.o_code(cal_code_w[c]),
			.o_lock(lock_w[c])
		);

		assign dly_rise = dly_r & ~dly_prev_r;
		assign dly_fall = ~dly_r & dly_prev_r;
		assign idle = (idle_cnt_r == IDLE_CYC);

		// next values of the half
		always_comb begin
			line_nxt = {line_r[TAPS-2:0], dqs_s_r}; // [RULE_06]
			dly_nxt = line_r[code_app_r]; // tap chosen by code [RULE_08]
			rise_q_nxt = dly_rise ? dq_s_r : rise_q_r; // [RULE_05]
			fall_q_nxt = dly_fall ? dq_s_r : fall_q_r; // [RULE_05]
			idle_cnt_nxt = (dly_rise | dly_fall) ? 5'h00 : (idle ? idle_cnt_r : idle_cnt_r + 5'h01);
			// first edge after quiet sets the polarity for the burst [RULE_07]
			pol_nxt = (idle && (dly_rise | dly_fall)) ? dly_rise : pol_r;
			// loop code taken only while the strobe is quiet [RULE_11] [RULE_09]
			code_app_nxt = idle ? cal_code_w[c] : code_app_r;
			sync_nxt = sync_r;
			dq_out_nxt = dq_out_r;
			if (rst_eff) begin
				sync_nxt = 2'h0;
				dq_out_nxt = 1'b0;
			end else if (ce_eff) begin
				// sync registers order the pair by polarity [RULE_07]
				if (sel_rise) begin
					sync_nxt = pol_r ? {fall_q_r, rise_q_r} : {rise_q_r, fall_q_r};
					dq_out_nxt = tx_r[c]; // [RULE_05]
				end else if (sel_fall) begin
					dq_out_nxt = tx_r[N_HALF+c]; // [RULE_05]
				end
			end
			oe_n_nxt = gts_r | ~ctrl_r[CTRL_OE_BIT];
		end

		// registers of the half
		always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
			if (!I_RST_N) begin
				dqs_m_r <= 1'b0;
				dqs_s_r <= 1'b0;
				dq_m_r <= 1'b0;
				dq_s_r <= 1'b0;
				line_r <= '0;
				dly_r <= 1'b0;
				dly_prev_r <= 1'b0;
				rise_q_r <= 1'b0;
				fall_q_r <= 1'b0;
				pol_r <= 1'b0;
				idle_cnt_r <= IDLE_CYC;
				code_app_r <= CODE_MAX;
				sync_r <= 2'h0;
				dq_out_r <= 1'b0;
				oe_n_r <= 1'b1;
			end else if (I_CE) begin
				dqs_m_r <= I_DQS[c];
				dqs_s_r <= dqs_m_r;
				dq_m_r <= I_DQ[c];
				dq_s_r <= dq_m_r;
				line_r <= line_nxt;
				dly_r <= dly_nxt;
				dly_prev_r <= dly_r;
				rise_q_r <= rise_q_nxt;
				fall_q_r <= fall_q_nxt;
				pol_r <= pol_nxt;
				idle_cnt_r <= idle_cnt_nxt;
				code_app_r <= code_app_nxt;
				sync_r <= sync_nxt;
				dq_out_r <= dq_out_nxt;
				oe_n_r <= oe_n_nxt;
			end
		end

		assign O_DQS_DLY[c] = dly_r;
		assign O_DQ[c] = dq_out_r;
		assign O_DQ_OE_N[c] = oe_n_r;
		assign dly_w[c] = dly_r;
		assign pol_w[c] = pol_r;
		assign idle_w[c] = idle;
		assign code_app_w[c] = code_app_r;
		assign sync_w[2*c+1:2*c] = sync_r;
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	// address and data taken in either order; response once both are held
	always_comb begin
		aw_ok_nxt = aw_ok_r;
		aw_addr_nxt = aw_addr_r;
		w_ok_nxt = w_ok_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		ctrl_nxt = ctrl_r;
		tx_nxt = tx_r;
		if (I_AXI_AWVALID && awready_r) begin
			aw_ok_nxt = 1'b1;
			aw_addr_nxt = I_AXI_AWADDR;
		end
		if (I_AXI_WVALID && wready_r) begin
			w_ok_nxt = 1'b1;
			w_data_nxt = I_AXI_WDATA;
			w_strb_nxt = I_AXI_WSTRB;
		end
		if (bvalid_r && I_AXI_BREADY) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_ok_r && w_ok_r && !bvalid_r) begin
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (aw_addr_r[7:2] == OFS_CTRL[7:2]) begin
				if (w_strb_r[0]) begin
					ctrl_nxt = w_data_r[6:0];
				end
			end else if (aw_addr_r[7:2] == OFS_TX[7:2]) begin
				if (w_strb_r[0]) begin
					tx_nxt = w_data_r[3:0];
				end
			end else if (aw_addr_r[7:2] == OFS_STAT[7:2] || aw_addr_r[7:2] == OFS_CODE[7:2]) begin
				bresp_nxt = RESP_OKAY; // read-only, write ignored
			end else begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		awready_nxt = !aw_ok_nxt && !bvalid_nxt;
		wready_nxt = !w_ok_nxt && !bvalid_nxt;
	end

	// read: data sampled at the address edge, one cycle later
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && I_AXI_RREADY) begin
			rvalid_nxt = 1'b0;
		end
		if (I_AXI_ARVALID && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (I_AXI_ARADDR[7:2] == OFS_CTRL[7:2]) begin
				rdata_nxt[6:0] = ctrl_r;
			end else if (I_AXI_ARADDR[7:2] == OFS_TX[7:2]) begin
				rdata_nxt[3:0] = tx_r;
			end else if (I_AXI_ARADDR[7:2] == OFS_STAT[7:2]) begin
				rdata_nxt[9:0] = {lock_w, idle_w, pol_w, sync_w};
			end else if (I_AXI_ARADDR[7:2] == OFS_CODE[7:2]) begin
				rdata_nxt = {2'h0, cal_code_w[1], 2'h0, cal_code_w[0], 2'h0, code_app_w[1], 2'h0, code_app_w[0]};
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_r <= CTRL_RST;
			tx_r <= TX_RST;
			aw_ok_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_ok_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else if (I_CE) begin
			ctrl_r <= ctrl_nxt;
			tx_r <= tx_nxt;
			aw_ok_r <= aw_ok_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_ok_r <= w_ok_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign O_AXI_AWREADY = awready_r;
	assign O_AXI_WREADY = wready_r;
	assign O_AXI_BVALID = bvalid_r;
	assign O_AXI_BRESP = bresp_r;
	assign O_AXI_ARREADY = arready_r;
	assign O_AXI_RVALID = rvalid_r;
	assign O_AXI_RDATA = rdata_r;
	assign O_AXI_RRESP = rresp_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_strobe_sel;
		(I_CE && ctrl_r[2:0] == SEL_STROBE) |=> ((O_SEL_CLK ^ $past(ctrl_r[CTRL_INV_BIT])) == $past(dly_w[0]));
	endproperty
	a_strobe_sel: assert property (p_strobe_sel) else $error("strobe net not selected"); // [RULE_01]

	property p_inv;
		(I_CE && ctrl_r[2] == 1'b0) |=> (O_SEL_CLK == ($past(rt_s_r[ctrl_r[1:0]]) ^ $past(ctrl_r[CTRL_INV_BIT])));
	endproperty
	a_inv: assert property (p_inv) else $error("routing clock inversion wrong"); // [RULE_02]

	property p_lsr;
		(I_CE && (I_IO_LSR ^ ctrl_r[CTRL_RST_INV_BIT])) |=> (sync_w == 4'h0 && O_DQ == 2'h0);
	endproperty
	a_lsr: assert property (p_lsr) else $error("local reset ignored"); // [RULE_03]

	property p_gts;
		I_CE |=> (O_GTS == $past(I_GTS)) ##1 (!$past(I_CE) || O_DQ_OE_N[0] == ($past(I_GTS, 2) | ~$past(ctrl_r[CTRL_OE_BIT])));
	endproperty
	a_gts: assert property (p_gts) else $error("tristate not forwarded"); // [RULE_04]

	property p_cap;
		(I_CE && (g_half[0].dly_rise)) |=> (g_half[0].rise_q_r == $past(g_half[0].dq_s_r));
	endproperty
	a_cap: assert property (p_cap) else $error("rising capture missed data"); // [RULE_05]

	property p_dly3;
		(I_CE && code_app_w[0] == 6'h03 && g_half[0].dqs_s_r) ##1 (I_CE && code_app_w[0] == 6'h03) [*4] |=> O_DQS_DLY[0];
	endproperty
	a_dly3: assert property (p_dly3) else $error("strobe delay not code plus two"); // [RULE_06] [RULE_08]

	property p_pol;
		(I_CE && idle_w[1] && (g_half[1].dly_rise || g_half[1].dly_fall)) |=> (pol_w[1] == $past(g_half[1].dly_rise));
	endproperty
	a_pol: assert property (p_pol) else $error("polarity not from first edge"); // [RULE_07]

	property p_code_hold;
		(code_app_w[0] != $past(code_app_w[0])) |-> ($past(idle_w[0]) && code_app_w[0] == $past(cal_code_w[0]));
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code changed inside a burst"); // [RULE_11]

	property p_half1;
		(code_app_w[1] != $past(code_app_w[1])) |-> (code_app_w[1] == $past(cal_code_w[1]));
	endproperty
	a_half1: assert property (p_half1) else $error("upper half took wrong loop"); // [RULE_09]

	property p_wr_resp;
		(I_CE && aw_ok_r && w_ok_r && !bvalid_r) |=> O_AXI_BVALID;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");

	c_burst: cover property (idle_w[0] ##1 !idle_w[0] [*3]);
	c_sync: cover property (sel_rise && ce_eff && !rst_eff && pol_w[0]);
	c_slverr: cover property (O_AXI_RVALID && O_AXI_RRESP == RESP_SLVERR);
endmodule : ddr_strobe_capture_control

/* dv/ddr_mem_model.sv */
// memory-side model: read bursts of strobe and data, loop feedback return
// assumes the bench raises i_burst for the span of one read burst
`timescale 1ns/1ps
module ddr_mem_model #(
	parameter realtime FB0_NS = 30.0,
	parameter realtime FB1_NS = 310.0
) (
	input wire logic i_burst,
	input wire logic [1:0] i_launch,
	output logic [1:0] o_dqs,
	output logic [1:0] o_dq,
	output logic [1:0] o_fb
);
	logic [1:0] pat_r; // data pattern, steps each strobe period
	initial begin
		o_dqs = 2'h0;
		o_dq = 2'h0;
		o_fb = 2'h0;
		pat_r = 2'h1;
	end
	// board traces hand the launch level back late; halves differ on purpose
	// return times sit off the core clock edges so the sampling flop never races them
	always @(i_launch[0]) o_fb[0] <= #(FB0_NS) i_launch[0];
	always @(i_launch[1]) o_fb[1] <= #(FB1_NS) i_launch[1];
	// strobe is not free running: low outside bursts, odd phase to the core clock
	always begin
		wait (i_burst);
		#37;
		while (i_burst) begin
			o_dqs = 2'h3;
			o_dq = pat_r;
			#100;
			o_dqs = 2'h0;
			o_dq = ~pat_r;
			#100;
			pat_r = pat_r + 2'h1;
		end
		// released data lines hold nothing useful: show the inverse
		o_dq = ~o_dq;
	end
endmodule : ddr_mem_model

/* dv/ddr_strobe_capture_control_bench.sv */
// self-checking bench: axi4-lite register tasks and directed port tests
// assumes dsc_pkg register map and the memory model beside this file
`timescale 1ns/1ps
module ddr_strobe_capture_control_bench;
	import dsc_pkg::*;
	logic clk, rst_n, ce, io_ce, io_lsr, gts, burst, sel_clk, gts_o;
	logic [3:0] rt_clk, wstrb;
	logic [1:0] dqs, dq, fb, launch, dqs_dly, dq_o, oe_n, bresp, rresp, rsp;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, rd;
	int num_errors, num_checks, n;
	ddr_strobe_capture_control ddr_strobe_capture_control_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
		.I_RT_CLK(rt_clk), .I_DQS(dqs), .I_DQ(dq), .I_IO_CE(io_ce), .I_IO_LSR(io_lsr), .I_GTS(gts),
		.I_CAL_FB(fb), .O_CAL_LAUNCH(launch), .O_DQS_DLY(dqs_dly), .O_DQ(dq_o), .O_DQ_OE_N(oe_n),
		.O_SEL_CLK(sel_clk), .O_GTS(gts_o), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
		.O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
		.O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
		.I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
		.O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready));
	ddr_mem_model ddr_mem_model_i (.i_burst(burst), .i_launch(launch), .o_dqs(dqs), .o_dq(dq), .o_fb(fb));
	// ----------------------------------------
	// clock and shared tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// write: address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 100);
		rsp = bresp;
		bready <= 1'b0;
		if (bvalid !== 1'b1)
			num_errors++;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		int t;
		t = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 100);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		if (rvalid !== 1'b1)
			num_errors++;
	endtask : axi_rd
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// watchdog: tests need about 2000 cycles
	initial begin
		cyc(20000);
		num_errors++;
		test_done();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst_n, io_ce, io_lsr, gts, burst, awvalid, wvalid, bready, arvalid, rready} = '0;
		ce = 1'b1;
		rt_clk = 4'h0;
		wstrb = 4'hf;
		{awaddr, araddr, wdata} = '0;
		cyc(12);
		rst_n <= 1'b1;
		cyc(2);
		// reset values, unmapped places
		axi_rd(OFS_CTRL);
		chk(rd, 32'h0000_0000);
		axi_rd(OFS_CODE);
		chk(32'(rd[5:0]), 32'(CODE_MAX));
		axi_rd(8'h40);
		chk(32'(rsp), 32'(RESP_SLVERR));
		axi_wr(8'h44, 32'h0000_00ff);
		chk(32'(rsp), 32'(RESP_SLVERR));
		$display("test reset_map done");
		// every routing clock, both senses
		for (int s = 0; s < 4; s++) begin
			for (int v = 0; v < 2; v++) begin
				axi_wr(OFS_CTRL, 32'(s + 8 * v));
				rt_clk <= 4'h1 << s;
				cyc(6);
				chk(32'(sel_clk), 32'(!v));
				rt_clk <= ~(4'h1 << s);
				cyc(6);
				chk(32'(sel_clk), 32'(v));
			end
		end
		$display("test clock_select done");
		// double-rate launch, enable polarity, tristate forwarding
		// park routing clock 0 low first so the selected clock really toggles below
		rt_clk <= 4'h0;
		axi_wr(OFS_TX, 32'h0000_0009);
		axi_wr(OFS_CTRL, 32'h0000_0040);
		io_ce <= 1'b1;
		rt_clk <= 4'h1;
		cyc(6);
		chk(32'(dq_o), 32'h0000_0001);
		rt_clk <= 4'h0;
		cyc(6);
		chk(32'(dq_o), 32'h0000_0002);
		chk(32'(oe_n), 32'h0000_0000);
		io_ce <= 1'b0;
		axi_wr(OFS_TX, 32'h0000_0004);
		rt_clk <= 4'h1;
		cyc(6);
		chk(32'(dq_o), 32'h0000_0002);
		axi_wr(OFS_CTRL, 32'h0000_0050);
		rt_clk <= 4'h0;
		cyc(6);
		rt_clk <= 4'h1;
		cyc(6);
		chk(32'(dq_o), 32'h0000_0000);
		gts <= 1'b1;
		cyc(3);
		chk(32'({gts_o, oe_n}), 32'h0000_0007);
		gts <= 1'b0;
		// local reset clears the launch register while enable is effective
		axi_wr(OFS_TX, 32'h0000_0003);
		rt_clk <= 4'h0;
		cyc(6);
		rt_clk <= 4'h1;
		cyc(6);
		chk(32'(dq_o), 32'h0000_0003);
		io_lsr <= 1'b1;
		cyc(2);
		chk(32'(dq_o), 32'h0000_0000);
		io_lsr <= 1'b0;
		$display("test ddr_out done");
		// both loops lock; the longer feedback gives the larger code
		cyc(1500);
		axi_rd(OFS_STAT);
		chk(32'(rd[9:8]), 32'h0000_0003);
		axi_rd(OFS_CODE);
		chk(32'(rd[29:24] > rd[21:16]), 32'h0000_0001);
		// 30 ns return: synchroniser plus one cycle gives three counted cycles
		chk(32'(rd[21:16]), 32'h0000_0003);
		chk(32'(rd[5:0]), 32'(rd[21:16]));
		chk(32'(rd[13:8]), 32'(rd[29:24]));
		$display("test calibration done");
		// burst: strobe delay follows the applied code, polarity set by first edge
		// selected clock taken from the lower-half strobe net, enable inverted, drive on
		axi_wr(OFS_CTRL, 32'h0000_0054);
		burst <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dqs[0] !== 1'b1 && n < 100);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (dqs_dly[0] !== 1'b1 && n < 200);
		// counted from the edge that first saw the pin high: code 3 plus three stages
		chk(32'(n), 32'h0000_0006);
		@(posedge clk);
		#1;
		chk(32'(sel_clk), 32'h0000_0001);
		axi_rd(OFS_STAT);
		chk(32'(rd[4]), 32'h0000_0001);
		burst <= 1'b0;
		cyc(40);
		$display("test strobe_burst done");
		test_done();
	end
endmodule : ddr_strobe_capture_control_bench
